// *** shared/wpc_pkg.sv ***
/*
  Shared constants, types and helpers for the wiper control logic of a
  one-time-programmable digital potentiometer.
  Assumes a single 50 MHz core clock and a serial host sending 16-bit frames.
*/
// Notes on behaviour
// RULE_01 - Wiper follows wiper register; all zeros puts wiper at low end.
// RULE_02 - Wiper register accepts unlimited writes.
// RULE_03 - Twenty fuse locations; latest stored value restored at power-up. Code resets used_reg, so power-up restores midscale.
// RULE_04 - Each store is verified afterwards; outcome goes to success flag.
// RULE_05 - Store lasts about 8 ms; shift register locked meanwhile.
// RULE_06 - Ready output shows store plus verify has finished.
// RULE_07 - Never-programmed memory gives midscale at power-up.
// RULE_08 - Power-up clears wiper write enable (bit 1).
// RULE_09 - Write-protected wiper ignores writes; refresh still works.
// RULE_10 - Host sets write enable with command 6 before wiper writes.
// RULE_11 - Program enable (bit 0) defaults 0; must be 1 to store.
// RULE_12 - Bit 2: 0 precision resistor mode (default), 1 normal mode.
// RULE_13 - Bit 3: 0 last store failed (default), 1 succeeded.
// RULE_14 - Command 1 loads wiper register from data when enabled.
// RULE_15 - Command 3 stores wiper into next free fuse location.
// RULE_16 - Command 5 reads location data[4:0] out in next frame.
// RULE_17 - Addresses 0x14 and 0x15 give thermometer usage record.
// RULE_18 - Host computes last address as ones count minus one.
// RULE_19 - Host may send 0x1803 first to enable both.
// RULE_20 - Command 7 returns control bits in low bits next frame.
// RULE_21 - Wiper code maps linearly; 0x100 is quarter scale.
// RULE_22 - Write-protected wiper stays at stored value or midscale.
// RULE_23 - Frame: MSB first, two zeros, command 13:10, ten data bits.
// RULE_24 - Frame select low for multiple of 16 clocks; decode on rise.
// RULE_25 - Reset pin rising edge restores wiper and control defaults.
// RULE_26 - Serial output changes on serial clock rising edge.
// RULE_27 - Store ignored if program disabled or memory full; flag cleared.
// RULE_28 - Program and lock time is a parameter, 8 ms by default.
package wpc_pkg;

  // Clock and timing
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned PROG_TIME_US_DEF = 8000;
  localparam int TIMER_W = 24;

  // Widths
  localparam int WIPER_W = 10;
  localparam int FRAME_W = 16;
  localparam int ADDR_W = 5;
  localparam int CNT_W = 5;
  localparam int CTRL_W = 4;
  localparam int BITCNT_W = 4;
  localparam int PIN_W = 4;
  localparam int OTP_DEPTH = 20;
  localparam int THERM_SPAN = 10;

  // Values
  localparam logic [WIPER_W-1:0] WIPER_MIDSCALE = 10'h200;
  localparam logic [WIPER_W-1:0] WIPER_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_STAT_LO = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_STAT_HI = 5'h15;
  localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 4'h0;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [5:0] RD_PAD6 = 6'h00;
  localparam logic [11:0] RD_PAD12 = 12'h000;
  localparam logic SDO_PULL_LEVEL = 1'b0;

  // Synchronised pin positions and their idle levels
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_RST = 3;
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'hA;

  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_WR_WIPER = 4'h1,
    CMD_RD_WIPER = 4'h2,
    CMD_STORE    = 4'h3,
    CMD_REFRESH  = 4'h4,
    CMD_RD_MEM   = 4'h5,
    CMD_WR_CTRL  = 4'h6,
    CMD_RD_CTRL  = 4'h7,
    CMD_SHUTDOWN = 4'h8
  } wpc_cmd_t;

  typedef struct packed {
    logic [1:0] pad;
    logic [3:0] cmd;
    logic [WIPER_W-1:0] data;
  } wpc_frame_t;

  typedef struct packed {
    logic nv_program_ok;
    logic calibration_select;
    logic wiper_write_enable;
    logic nv_program_enable;
  } wpc_ctrl_t;

  localparam wpc_ctrl_t CTRL_RESET = 4'h0;

  typedef enum logic [1:0] {
    OTP_IDLE   = 2'h0,
    OTP_BURN   = 2'h1,
    OTP_VERIFY = 2'h3
  } wpc_otp_state_t;

  // Thermometer word: one set bit per programming beyond offset
  function automatic logic [WIPER_W-1:0] wpc_therm(
    input logic [CNT_W-1:0] used,
    input int offset
  );
    logic [WIPER_W-1:0] r;
    r = '0;
    for (int i = 0; i < WIPER_W; i++) begin
      r[i] = (int'(used) > offset + i);
    end
    return r;
  endfunction

endpackage

// *** hdl/wpc_otp_array.sv ***
/*
  Twenty-location fuse array with programming timer, verify step,
  readback mux and thermometer usage words.
  Assumes the caller starts a store only when not busy and not full.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_otp_array
  import wpc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 400000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_start_i,
  input wire logic [WIPER_W-1:0] prog_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WIPER_W-1:0] rd_data_o,
  output logic [WIPER_W-1:0] restore_data_o,
  output logic [CNT_W-1:0] used_cnt_o,
  output logic busy_o,
  output logic done_o,
  output logic ok_o
);

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(PROG_CYCLES - 1);

  // Fuse contents keep no reset: they model nonvolatile cells
  logic [WIPER_W-1:0] otp_mem_reg [OTP_DEPTH];
  wpc_otp_state_t state_reg;
  wpc_otp_state_t state_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [CNT_W-1:0] used_reg;
  logic [WIPER_W-1:0] data_reg;
  logic done_reg;
  logic ok_reg;
  wire logic burn_end = (state_reg == OTP_BURN) && (timer_reg == TIMER_LAST);
  wire logic verify_pass = (otp_mem_reg[used_reg] == data_reg);
  wire logic in_range = (rd_addr_i < CNT_FULL);
  wire logic programmed = (rd_addr_i < used_reg);

  // Store sequence: burn for the full time, then check the cell
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      OTP_IDLE:   if (prog_start_i) state_next = OTP_BURN;
      OTP_BURN:   if (burn_end) state_next = OTP_VERIFY;
      OTP_VERIFY: state_next = OTP_IDLE;
      default:    state_next = OTP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= OTP_IDLE;
      timer_reg <= '0;
      used_reg <= '0;
      data_reg <= '0;
      done_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= (state_reg == OTP_BURN) ? timer_reg + 1'b1 : '0; // RULE_05
      done_reg <= (state_reg == OTP_VERIFY);
      if (prog_start_i && state_reg == OTP_IDLE) begin
        data_reg <= prog_data_i;
      end
      if (state_reg == OTP_VERIFY) begin
        ok_reg <= verify_pass; // RULE_04
        used_reg <= used_reg + CNT_ONE;
      end
    end
  end

  // Cell written as the burn ends, read back in the verify cycle
  always_ff @(posedge clk_i) begin
    if (burn_end) begin
      otp_mem_reg[used_reg] <= data_reg; // RULE_15
    end
  end

  // Readback: fuses, then the two usage words, else zero
  always_comb begin
    rd_data_o = WIPER_ZERO;
    if (in_range && programmed) begin
      rd_data_o = otp_mem_reg[rd_addr_i]; // RULE_16
    end else if (rd_addr_i == ADDR_STAT_LO) begin
      rd_data_o = wpc_therm(used_reg, 0); // RULE_17
    end else if (rd_addr_i == ADDR_STAT_HI) begin
      rd_data_o = wpc_therm(used_reg, THERM_SPAN); // RULE_17
    end
  end

  // Latest stored value, or midscale on a fresh part
  assign restore_data_o = (used_reg == '0) ? WIPER_MIDSCALE
                          : otp_mem_reg[used_reg - CNT_ONE]; // RULE_03 RULE_07
  assign used_cnt_o = used_reg;
  assign busy_o = (state_reg != OTP_IDLE);
  assign done_o = done_reg;
  assign ok_o = ok_reg;

endmodule
`default_nettype wire

// *** hdl/wpc_wiper_ctrl.sv ***
/*
  Top of the wiper control logic: serial frame receiver and readback
  shifter, command decode, wiper register, control bits, fuse store and
  ready indication.
  Assumes serial pins and the reset pin are asynchronous to core_clk_i
  and that the serial clock is well below a quarter of the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_wiper_ctrl
  import wpc_pkg::*;
#(
  parameter int unsigned PROG_TIME_US = PROG_TIME_US_DEF
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  input wire logic hw_restore_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic rdy_o,
  output logic [WIPER_W-1:0] wiper_code_o,
  output logic wiper_at_low_end_o,
  output logic calibration_select_o,
  output logic nv_program_ok_o
);

  // Store time in cycles, never below one cycle
  localparam int unsigned PROG_CYCLES_RAW = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned PROG_CYCLES =
    (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW; // RULE_28

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire logic rst_n = rst_sync_reg;

  // Pin synchronisers
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [PIN_W-1:0] pin_last_reg;
  wire logic [PIN_W-1:0] pin_raw = {hw_restore_n_i, din_i, sync_n_i, sclk_i};

  // Frame state
  logic [FRAME_W-1:0] sr_reg;
  logic [FRAME_W-1:0] sr_next;
  logic [BITCNT_W-1:0] bitcnt_reg;
  logic seen_reg;
  logic sdo_reg;

  // Device state
  logic [WIPER_W-1:0] wiper_reg;
  logic [WIPER_W-1:0] wiper_next;
  wpc_ctrl_t ctrl_reg;
  wpc_ctrl_t ctrl_next;
  logic boot_reg;
  logic rdy_reg;
  logic low_end_reg;

  // Fuse array links
  logic [WIPER_W-1:0] otp_rd_data;
  logic [WIPER_W-1:0] otp_restore;
  logic [CNT_W-1:0] otp_used;
  logic otp_busy;
  logic otp_done;
  logic otp_ok;

  // Reset is asserted at once but released through two flops
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Three flops per pin; edge detection reads the second and third stages
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= PIN_IDLE;
      pin_sync_reg <= PIN_IDLE;
      pin_last_reg <= PIN_IDLE;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  // Edges of the synchronised pins
  wire logic sclk_rise = pin_sync_reg[PIN_SCLK] & ~pin_last_reg[PIN_SCLK];
  wire logic sclk_fall = ~pin_sync_reg[PIN_SCLK] & pin_last_reg[PIN_SCLK];
  wire logic frame_on = ~pin_sync_reg[PIN_SYNC];
  wire logic sync_fall = ~pin_sync_reg[PIN_SYNC] & pin_last_reg[PIN_SYNC];
  wire logic sync_rise = pin_sync_reg[PIN_SYNC] & ~pin_last_reg[PIN_SYNC];
  wire logic pin_restore =
    pin_sync_reg[PIN_RST] & ~pin_last_reg[PIN_RST]; // RULE_25
  wire logic din_bit = pin_sync_reg[PIN_DIN];

  // Shifting and command decode freeze while a store runs
  wire logic lock = otp_busy; // RULE_05
  wire logic shift_en = frame_on & sclk_fall & ~lock;

  // Decode happens only for whole multiples of sixteen clocks
  wire logic frame_ok = seen_reg & (bitcnt_reg == BITCNT_ZERO); // RULE_24
  wire logic cmd_go = sync_rise & frame_ok & ~lock; // RULE_24
  wire wpc_frame_t frm = wpc_frame_t'(sr_reg); // RULE_23
  wire wpc_cmd_t cmd = wpc_cmd_t'(frm.cmd);

  // Command strobes
  wire logic is_wr_wiper = cmd_go & (cmd == CMD_WR_WIPER);
  wire logic is_rd_wiper = cmd_go & (cmd == CMD_RD_WIPER);
  wire logic is_store = cmd_go & (cmd == CMD_STORE);
  wire logic is_refresh = cmd_go & (cmd == CMD_REFRESH);
  wire logic is_rd_mem = cmd_go & (cmd == CMD_RD_MEM);
  wire logic is_wr_ctrl = cmd_go & (cmd == CMD_WR_CTRL);
  wire logic is_rd_ctrl = cmd_go & (cmd == CMD_RD_CTRL);

  // Gated actions
  wire logic wiper_load =
    is_wr_wiper & ctrl_reg.wiper_write_enable; // RULE_09 RULE_14
  wire logic store_go = is_store & ctrl_reg.nv_program_enable
                        & (otp_used < CNT_FULL); // RULE_11 RULE_27
  wire logic restore_go = boot_reg | is_refresh | pin_restore; // RULE_09
  wire logic ctrl_default = boot_reg | pin_restore; // RULE_08 RULE_25

  // Readback words, padded so the value sits in the low bits
  wire logic [FRAME_W-1:0] rd_wiper_word = {RD_PAD6, wiper_reg};
  wire logic [FRAME_W-1:0] rd_mem_word = {RD_PAD6, otp_rd_data}; // RULE_16
  wire logic [FRAME_W-1:0] rd_ctrl_word = {RD_PAD12, ctrl_reg}; // RULE_20

  // Shift register: serial in, or a readback word after a read command.
  // Other commands leave the last word in place, so it echoes out next.
  always_comb begin
    sr_next = sr_reg;
    if (shift_en) begin
      sr_next = {sr_reg[FRAME_W-2:0], din_bit}; // RULE_23
    end else if (is_rd_wiper) begin
      sr_next = rd_wiper_word;
    end else if (is_rd_mem) begin
      sr_next = rd_mem_word; // RULE_16
    end else if (is_rd_ctrl) begin
      sr_next = rd_ctrl_word; // RULE_20
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= '0;
    end else begin
      sr_reg <= sr_next;
    end
  end

  // Bit counter wraps every sixteen bits; cleared at each frame edge
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt_reg <= BITCNT_ZERO;
      seen_reg <= 1'b0;
    end else if (sync_fall || sync_rise) begin
      bitcnt_reg <= BITCNT_ZERO;
      seen_reg <= 1'b0;
    end else if (shift_en) begin
      bitcnt_reg <= bitcnt_reg + BITCNT_ONE;
      seen_reg <= 1'b1;
    end
  end

  // Output bit: presented at frame start, advanced on serial rises
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sdo_reg <= 1'b1;
    end else if (sync_fall || (frame_on && sclk_rise)) begin
      sdo_reg <= sr_reg[FRAME_W-1]; // RULE_26
    end
  end

  // Wiper register: restores win over a write in the same cycle
  always_comb begin
    wiper_next = wiper_reg; // RULE_22
    if (restore_go) begin
      wiper_next = otp_restore; // RULE_03 RULE_07 RULE_09
    end else if (wiper_load) begin
      wiper_next = frm.data; // RULE_02 RULE_14
    end
  end

  // Control bits; the success flag set by a finished store wins
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_default) begin
      ctrl_next = CTRL_RESET; // RULE_08 RULE_11 RULE_25
    end else if (is_wr_ctrl) begin
      ctrl_next.nv_program_enable = frm.data[0]; // RULE_11
      ctrl_next.wiper_write_enable = frm.data[1]; // RULE_10
      ctrl_next.calibration_select = frm.data[2]; // RULE_12
    end
    if (is_store) begin
      ctrl_next.nv_program_ok = 1'b0; // RULE_27
    end
    if (otp_done) begin
      ctrl_next.nv_program_ok = otp_ok; // RULE_04 RULE_13
    end
  end

  // Boot restore runs once in the first cycle after reset release
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wiper_reg <= WIPER_MIDSCALE;
      ctrl_reg <= CTRL_RESET;
      boot_reg <= 1'b1;
    end else begin
      wiper_reg <= wiper_next;
      ctrl_reg <= ctrl_next;
      boot_reg <= 1'b0;
    end
  end

  // Status outputs, all from flops
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdy_reg <= 1'b1;
      low_end_reg <= 1'b0;
    end else begin
      rdy_reg <= ~otp_busy & ~store_go; // RULE_06
      low_end_reg <= (wiper_next == WIPER_ZERO); // RULE_01
    end
  end

  wpc_otp_array #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_otp (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .prog_start_i(store_go),
    .prog_data_i(wiper_reg),
    .rd_addr_i(frm.data[ADDR_W-1:0]),
    .rd_data_o(otp_rd_data),
    .restore_data_o(otp_restore),
    .used_cnt_o(otp_used),
    .busy_o(otp_busy),
    .done_o(otp_done),
    .ok_o(otp_ok)
  );

  // Open-drain output: only ever pulls low, and only inside a frame
  assign sdo_o = SDO_PULL_LEVEL;
  assign sdo_oe_o = frame_on & ~sdo_reg; // RULE_26
  assign rdy_o = rdy_reg; // RULE_06
  assign wiper_code_o = wiper_reg; // RULE_01 RULE_21
  assign wiper_at_low_end_o = low_end_reg; // RULE_01
  assign calibration_select_o = ctrl_reg.calibration_select; // RULE_12
  assign nv_program_ok_o = ctrl_reg.nv_program_ok; // RULE_13

endmodule
`default_nettype wire

// *** tb/wpc_wiper_ctrl_props.sv ***
/*
  Checker for the wiper control top, bound to its ports.
  Assumes one core clock domain reset by arst_n_i.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_wiper_ctrl_props
  import wpc_pkg::*;
#(
  parameter int unsigned PROG_TIME_US = PROG_TIME_US_DEF
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  input wire logic hw_restore_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic rdy_o,
  input wire logic [WIPER_W-1:0] wiper_code_o,
  input wire logic wiper_at_low_end_o,
  input wire logic calibration_select_o,
  input wire logic nv_program_ok_o
);
  localparam int BUSY_MIN = PROG_TIME_US * CLK_FREQ_MHZ - 1;
  localparam int BUSY_MAX = BUSY_MIN + 8;
  logic sclk_q, sync_q, pin_q;
  logic [7:0] sclk_age, sync_age, pin_age, low_cnt;
  logic [TIMER_W-1:0] busy_cnt;
  // Saturating age so a long idle never wraps into a window
  function automatic logic [7:0] age(input logic hit, input logic [7:0] a);
    return hit ? 8'h00 : ((a == 8'hFF) ? a : a + 8'h01);
  endfunction
  // Cycles since pin edges, select low time and store length
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
      pin_q <= 1'b1;
      sclk_age <= 8'hFF;
      sync_age <= 8'hFF;
      pin_age <= 8'hFF;
      low_cnt <= 8'h00;
      busy_cnt <= '0;
    end else begin
      sclk_q <= sclk_i;
      sync_q <= sync_n_i;
      pin_q <= hw_restore_n_i;
      sclk_age <= age(sclk_i && !sclk_q, sclk_age);
      sync_age <= age(sync_n_i && !sync_q, sync_age);
      pin_age <= age(hw_restore_n_i && !pin_q, pin_age);
      low_cnt <= sync_n_i ? 8'h00 : age(1'b0, low_cnt);
      busy_cnt <= rdy_o ? '0 : busy_cnt + 1'b1;
    end
  end
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence store_begins;
    rdy_o ##1 !rdy_o;
  endsequence
  sequence busy_steady;
    (!rdy_o && hw_restore_n_i)[*6];
  endsequence
  reset_vals_a: assert property (
    $rose(arst_n_i) |-> wiper_code_o == WIPER_MIDSCALE && rdy_o
      && !nv_program_ok_o && !calibration_select_o)
    else $error("wrong state at reset release");
  low_end_a: assert property (
    wiper_at_low_end_o == (wiper_code_o == WIPER_ZERO))
    else $error("low end flag disagrees with wiper");
  ok_clear_a: assert property (
    store_begins |-> ##[0:1] !nv_program_ok_o)
    else $error("success flag kept at store start");
  busy_len_a: assert property (
    $rose(rdy_o) |-> busy_cnt >= BUSY_MIN && busy_cnt <= BUSY_MAX)
    else $error("store busy time wrong");
  store_lock_a: assert property (
    busy_steady |-> $stable(wiper_code_o) && $stable(calibration_select_o))
    else $error("state changed during store");
  ok_rise_end_a: assert property (
    $rose(nv_program_ok_o) |-> !$past(rdy_o, 1) || !$past(rdy_o, 2))
    else $error("success flag set outside a store");
  oe_idle_a: assert property (
    sync_n_i[*6] |-> !sdo_oe_o)
    else $error("data line driven between frames");
  sdo_edge_a: assert property (
    $changed(sdo_oe_o) && !sync_n_i && low_cnt > 8'h07
      |-> sclk_age >= 8'h01 && sclk_age <= 8'h06)
    else $error("data out changed away from clock rise");
  wiper_cause_a: assert property (
    $changed(wiper_code_o) |-> (sync_age >= 8'h01 && sync_age <= 8'h0A)
      || (pin_age >= 8'h01 && pin_age <= 8'h0A))
    else $error("wiper moved without frame or reset pin");
endmodule
bind wpc_wiper_ctrl wpc_wiper_ctrl_props #(.PROG_TIME_US(PROG_TIME_US))
  u_wpc_wiper_ctrl_props (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .sclk_i(sclk_i), .sync_n_i(sync_n_i), .din_i(din_i),
  .hw_restore_n_i(hw_restore_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .rdy_o(rdy_o), .wiper_code_o(wiper_code_o),
  .wiper_at_low_end_o(wiper_at_low_end_o),
  .calibration_select_o(calibration_select_o),
  .nv_program_ok_o(nv_program_ok_o));
`default_nettype wire

// *** tb/wpc_host_model.sv ***
/*
  Host serial master sending frames of up to 32 bits, MSB first.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o
);
  // Clock idles low, select high
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end
  // One frame; r keeps the last 16 bits seen, sampled after each fall.
  // The device moves its output on the rise, so a sample taken just
  // before the next rise still shows the bit of the previous clock.
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    sync_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      din_o <= w[i];
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      r = {r[14:0], sdo_i};
    end
    @(posedge clk_i);
    sync_n_o <= 1'b1;
    din_o <= ~din_o; // Released line shows no stale bit
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** tb/wpc_wiper_ctrl_test.sv ***
/*
  Self-checking bench for the wiper control top with a host model.
  Assumes a short store time set through PROG_TIME_US.
*/
`timescale 1ns/10ps
`default_nettype none
module wpc_wiper_ctrl_test import wpc_pkg::*;;
  localparam int unsigned PT = 20;
  localparam int LIM = PT * CLK_FREQ_MHZ + 400;
  logic core_clk = 1'b0;
  logic arst_n, hw_n, sclk, sync_n, din, sdo, sdo_oe, sdo_w, rdy;
  logic low_end, calsel, ok;
  logic [WIPER_W-1:0] wiper;
  logic [15:0] rb, rb2;
  int errors, total_checks;
  always #10 core_clk = ~core_clk;
  // Open-drain line with pull-up
  assign sdo_w = sdo_oe ? sdo : 1'b1;
  wpc_wiper_ctrl #(.PROG_TIME_US(PT)) u_wpc_wiper_ctrl (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .sclk_i(sclk),
    .sync_n_i(sync_n), .din_i(din), .hw_restore_n_i(hw_n), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .rdy_o(rdy), .wiper_code_o(wiper),
    .wiper_at_low_end_o(low_end), .calibration_select_o(calsel),
    .nv_program_ok_o(ok));
  wpc_host_model u_wpc_host_model (.clk_i(core_clk), .sdo_i(sdo_w),
    .sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd(input logic [15:0] w);
    logic [15:0] r;
    u_wpc_host_model.frame({16'h0000, w}, 16, r);
  endtask
  // Read commands answer in the following frame
  task automatic rd(input logic [15:0] w, output logic [15:0] r);
    cmd(w);
    u_wpc_host_model.frame(32'h0000_0000, 16, r);
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < LIM) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= LIM) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic pulse_pin;
    hw_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    hw_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic store(input logic [9:0] v);
    cmd({6'h01, v});
    cmd(16'h0C00);
    chk("busy", 16'(rdy), 16'h0000);
    wait_rdy();
    chk("store ok", 16'(ok), 16'h0001);
  endtask
  task automatic t_defaults;
    chk("wiper", 16'(wiper), 16'h0200);
    chk("cal sel", 16'(calsel), 16'h0000);
    chk("ok flag", 16'(ok), 16'h0000);
    rd(16'h1C00, rb);
    chk("ctrl read", rb, 16'h0000);
    rd(16'h0800, rb);
    chk("wiper read", rb, 16'h0200);
    cmd(16'h0500);
    chk("protected", 16'(wiper), 16'h0200);
  endtask
  task automatic t_write;
    cmd(16'h1803);
    cmd(16'h0500);
    chk("quarter", 16'(wiper), 16'h0100);
    cmd(16'h0400);
    chk("low end", 16'(low_end), 16'h0001);
    u_wpc_host_model.frame(32'h0000_07FF, 15, rb);
    chk("short frame", 16'(wiper), 16'h0000);
    cmd(16'h0555);
    rd(16'h0800, rb);
    chk("wiper read", rb, 16'h0155);
  endtask
  task automatic t_store;
    cmd(16'h0C00);
    chk("busy", 16'(rdy), 16'h0000);
    cmd(16'h07FF);
    wait_rdy();
    chk("locked", 16'(wiper), 16'h0155);
    rd(16'h1C00, rb);
    chk("ctrl read", rb, 16'h000B);
    rd(16'h1400, rb);
    chk("mem 0", rb, 16'h0155);
    rd(16'h1414, rb);
    chk("status lo", rb, 16'h0001);
    cmd(16'h1802);
    cmd(16'h0C00);
    chk("no store", 16'(rdy), 16'h0001);
    chk("flag clr", 16'(ok), 16'h0000);
  endtask
  task automatic t_restore;
    cmd(16'h1807);
    chk("cal sel", 16'(calsel), 16'h0001);
    cmd(16'h07FF);
    pulse_pin();
    chk("pin wiper", 16'(wiper), 16'h0155);
    chk("pin ctrl", 16'(calsel), 16'h0000);
    cmd(16'h0400);
    chk("protected", 16'(wiper), 16'h0155);
    cmd(16'h1802);
    cmd(16'h07FF);
    cmd(16'h1000);
    chk("refresh", 16'(wiper), 16'h0155);
  endtask
  task automatic t_fill;
    cmd(16'h1803);
    for (int k = 1; k < 20; k++) store(10'(k));
    rd(16'h1414, rb);
    rd(16'h1415, rb2);
    chk("status", {rb[9:0], rb2[5:0]}, 16'hFFFF);
    chk("last addr", 16'($countones({rb, rb2}) - 1), 16'h0013);
    rd(16'h1413, rb);
    chk("mem 19", rb, 16'h0013);
    cmd(16'h0C00);
    chk("full", 16'(rdy), 16'h0001);
    chk("full flag", 16'(ok), 16'h0000);
    pulse_pin();
    chk("latest", 16'(wiper), 16'h0013);
  endtask
  // Reset, then scenarios in order; each leaves state the next relies on
  initial begin
    arst_n = 1'b0;
    hw_n = 1'b1;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_defaults();
    t_write();
    t_store();
    t_restore();
    t_fill();
    finish_test();
  end
endmodule
`default_nettype wire
